// ---- memory_map_unit_control.sv ----
`timescale 1ns/1ns
// Operation
// [R1] Page lookup read returns mapped physical page in bits 9-15.
// [R2] Page lookup read echoes request bits 0-6; bits 7-8 read zero.
// [R3] Request: bit 0 map select, bits 1-5 page, bit 6 bank.
// [R4] Status read returns the full 16-bit status word.
// [R5] Status bits 0 and 1 enable program and channel translation.
// [R6] Status bit 2 suppresses program translation.
// [R7] Status bit 6 selects utility map over program enable and bank.
// [R8] Bits 7-8 pick the map filled or dumped by block transfers.
// [R9] Bit 10 picks single-cycle bank; bit 15 picks program bank.
// [R10] Status write loads the word and forces inhibit to zero.
// [R11] Software zeroes reserved status bits; bit 5 is diagnostic only.
// [R12] Single-cycle command maps only the second following program reference.
// [R13] Clear-map disables translation and reinitialises all map state; the code does not clear the map table entries.
// [R14] Block load reads up to 64 entries, stopping at all-ones word.
// [R15] Entry: logical page bits 0-5, zeros 6-7, physical bits 8-15.
// [R16] Block store writes 64 entries of the target map to memory.
// [R17] Responds on device code 2 and auxiliary device code 3.
// [R18] Any interrupt request sets the program inhibit bit at once.
// [R19] Reset leaves the same state as clear-map.
module memory_map_unit_control
  import map_unit_pkg::*;
#(
  parameter int entry_width = 8
)
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        io_strobe,
  input  wire logic [2:0]  io_op,
  input  wire logic [1:0]  io_flag,
  input  wire logic [5:0]  io_code,
  input  wire logic [15:0] io_wdata,
  output logic      [15:0] io_rdata,
  output logic             io_done,
  output logic             busy,
  input  wire logic        int_request,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [15:0] mem_addr,
  output logic      [15:0] mem_wdata,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        mem_ack,
  input  wire logic        ref_valid,
  input  wire logic        ref_channel,
  input  wire logic        ref_indirect,
  input  wire logic [5:0]  ref_page,
  output logic      [7:0]  mapped_page,
  output logic             mapped_valid,
  output logic             mapped_translated,
  output logic      [15:0] translation_status_word
);

  // ****************************************
  // Command decode
  // ****************************************
  logic cmd_main;
  logic cmd_aux;
  logic accept;
  logic map_clear;
  logic sc_start;
  logic status_write;
  logic status_read;
  logic lookup_write;
  logic lookup_read;
  logic entry_write;
  logic block_load;
  logic block_dump;

  assign cmd_main     = io_strobe && (io_code == map_main_code);  // [R17]
  assign cmd_aux      = io_strobe && (io_code == map_aux_code);   // [R17]
  assign map_clear    = !resetn || (cmd_aux && io_flag == flag_clear);  // [R13] [R19]
  assign accept       = (cmd_main || cmd_aux) && !busy;
  assign sc_start     = accept && cmd_main && io_flag == flag_pulse;
  assign status_write = accept && cmd_main && io_op == op_data_out_first;
  assign status_read  = accept && cmd_main && io_op == op_data_in_first;
  assign lookup_write = accept && cmd_aux && io_op == op_data_out_first;
  assign lookup_read  = accept && cmd_aux && io_op == op_data_in_first;
  assign entry_write  = accept && cmd_main && io_op == op_data_out_second;
  assign block_load   = accept && cmd_main && io_op == op_data_out_third;
  assign block_dump   = accept && cmd_main && io_op == op_data_in_third;

  // ****************************************
  // Status word
  // ****************************************
  logic [15:0] next_status;
  logic        program_armed;
  logic [1:0]  table_target;

  assign table_target = translation_status_word[st_target_hi:st_target_lo];  // [R8]

  always_comb
  begin
    next_status = translation_status_word;
    if (status_write)
    begin
      next_status = io_wdata;
      next_status[st_inhibit] = 1'b0;  // [R10]
    end
    if (int_request)
    begin
      next_status[st_inhibit] = 1'b1;  // [R18]
    end
  end

  always_ff @(posedge clk)
  begin
    if (map_clear)
    begin
      translation_status_word <= status_reset;  // [R13] [R19]
    end
    else
    begin
      translation_status_word <= next_status;
    end
  end

  // Program map goes live after the first indirect reference
  always_ff @(posedge clk)
  begin
    if (map_clear || status_write)
    begin
      program_armed <= 1'b0;
    end
    else if (ref_valid && ref_indirect && translation_status_word[st_prog_on])
    begin
      program_armed <= 1'b1;
    end
  end

  // ****************************************
  // Map table
  // ****************************************
  logic                   wr_en;
  logic [1:0]             wr_map;
  logic [5:0]             wr_page;
  logic [entry_width-1:0] wr_data;
  logic [1:0]             xlate_map;
  logic [entry_width-1:0] xlate_entry;
  logic [1:0]             side_map;
  logic [5:0]             side_page;
  logic [entry_width-1:0] side_entry;
  xfer_state_type         xfer_state;
  logic [6:0]             xfer_count;
  logic                   fetch_take;

  assign fetch_take = xfer_state == xfer_fetch && mem_req && mem_ack
                      && mem_rdata != end_marker;

  always_comb
  begin
    wr_en   = entry_write || fetch_take;
    wr_map  = map_pick(io_wdata[rq_sel], io_wdata[rq_bank]);
    wr_page = {1'b0, io_wdata[rq_page_hi:rq_page_lo]};
    wr_data = {1'b0, io_wdata[res_phys_hi:0]};
    if (fetch_take)
    begin
      wr_map  = table_target;                              // [R8]
      wr_page = mem_rdata[ent_page_hi:ent_page_lo];        // [R15]
      wr_data = mem_rdata[ent_phys_hi:0];                  // [R15]
    end
  end

  always_comb
  begin
    side_map  = table_target;                              // [R16]
    side_page = xfer_count[5:0];
    if (xfer_state == xfer_idle && !block_dump)
    begin
      side_map  = map_pick(io_wdata[rq_sel], io_wdata[rq_bank]);  // [R3]
      side_page = {1'b0, io_wdata[rq_page_hi:rq_page_lo]};         // [R3]
    end
  end

  map_table_store #(
    .maps  (4),
    .pages (64),
    .width (entry_width)
  ) u_store (
    .clk       (clk),
    .wr_en     (wr_en),
    .wr_map    (wr_map),
    .wr_page   (wr_page),
    .wr_data   (wr_data),
    .rd_a_map  (xlate_map),
    .rd_a_page (ref_page),
    .rd_a_data (xlate_entry),
    .rd_b_map  (side_map),
    .rd_b_page (side_page),
    .rd_b_data (side_entry)
  );

  // ****************************************
  // Page lookup
  // ****************************************
  logic [15:0] page_lookup_result;

  always_ff @(posedge clk)
  begin
    if (map_clear)
    begin
      page_lookup_result <= 16'h0000;
    end
    else if (lookup_write)
    begin
      page_lookup_result <= {io_wdata[15:rq_keep_lo + 2], 2'h0,
                             side_entry[res_phys_hi:0]};  // [R1] [R2]
    end
  end

  // ****************************************
  // Command answers
  // ****************************************
  logic xfer_end;

  always_ff @(posedge clk)
  begin
    if (map_clear)
    begin
      io_rdata <= 16'h0000;
    end
    else if (status_read)
    begin
      io_rdata <= translation_status_word;  // [R4]
    end
    else if (lookup_read)
    begin
      io_rdata <= page_lookup_result;       // [R1] [R2]
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      io_done <= 1'b0;
    end
    else
    begin
      io_done <= (accept && !block_load && !block_dump) || xfer_end
                 || (cmd_aux && io_flag == flag_clear);
    end
  end

  // ****************************************
  // Block transfer sequencer
  // ****************************************
  logic last_word;

  assign last_word = xfer_count == block_words - 7'h1;
  assign xfer_end  = mem_req && mem_ack && (xfer_state == xfer_store ? last_word
                     : (last_word || mem_rdata == end_marker));  // [R14] [R16]

  always_ff @(posedge clk)
  begin
    if (map_clear)
    begin
      xfer_state <= xfer_idle;
      busy       <= 1'b0;
      mem_req    <= 1'b0;
      mem_we     <= 1'b0;
      mem_addr   <= 16'h0000;
      mem_wdata  <= 16'h0000;
      xfer_count <= 7'h00;
    end
    else
    begin
      unique case (xfer_state)
        xfer_idle:
        begin
          xfer_count <= 7'h00;
          mem_addr   <= io_wdata;
          if (block_load)
          begin
            xfer_state <= xfer_fetch;  // [R14]
            busy       <= 1'b1;
            mem_req    <= 1'b1;
            mem_we     <= 1'b0;
          end
          else if (block_dump)
          begin
            xfer_state <= xfer_store;  // [R16]
            busy       <= 1'b1;
            mem_req    <= 1'b1;
            mem_we     <= 1'b1;
            mem_wdata  <= {6'h00, 2'h0, side_entry};  // [R15]
          end
        end
        xfer_fetch, xfer_store:
        begin
          if (xfer_end)
          begin
            xfer_state <= xfer_idle;
            xfer_count <= 7'h00;
            busy       <= 1'b0;
            mem_req    <= 1'b0;
            mem_we     <= 1'b0;
          end
          else if (mem_req && mem_ack)
          begin
            mem_req    <= 1'b0;
            mem_addr   <= mem_addr + 16'h0001;
            xfer_count <= xfer_count + 7'h01;
          end
          else if (!mem_req)
          begin
            mem_req   <= 1'b1;
            mem_wdata <= {xfer_count[5:0], 2'h0, side_entry};  // [R15] [R16]
          end
        end
      endcase
    end
  end

  // ****************************************
  // Address translation
  // ****************************************
  logic sc_hit;
  logic program_live;

  single_cycle_tracker u_single (
    .clk     (clk),
    .resetn  (resetn),
    .clear   (map_clear),
    .start   (sc_start),
    .cpu_ref (ref_valid && !ref_channel),
    .hit     (sc_hit)
  );

  assign program_live = translation_status_word[st_prog_on] && program_armed
                        && !translation_status_word[st_inhibit];  // [R5] [R6]

  always_comb
  begin
    if (ref_channel)
    begin
      xlate_map = map_channel;
    end
    else if (sc_hit)
    begin
      xlate_map = translation_status_word[st_sc_bank] ? map_bank_b : map_bank_a;  // [R9] [R12]
    end
    else if (translation_status_word[st_utility_on])
    begin
      xlate_map = map_utility;  // [R7]
    end
    else
    begin
      xlate_map = translation_status_word[st_prog_bank] ? map_bank_b : map_bank_a;  // [R9]
    end
  end

  always_ff @(posedge clk)
  begin
    if (map_clear)
    begin
      mapped_page       <= 8'h00;
      mapped_valid      <= 1'b0;
      mapped_translated <= 1'b0;
    end
    else
    begin
      mapped_valid <= ref_valid;
      if (ref_valid)
      begin
        if ((ref_channel && translation_status_word[st_chan_on])        // [R5]
            || (!ref_channel && (sc_hit                                 // [R12]
            || (!translation_status_word[st_inhibit]                    // [R6]
                && translation_status_word[st_utility_on])              // [R7]
            || program_live)))
        begin
          mapped_page       <= xlate_entry;
          mapped_translated <= 1'b1;
        end
        else
        begin
          mapped_page       <= {2'h0, ref_page};
          mapped_translated <= 1'b0;
        end
      end
    end
  end

endmodule

// ---- map_unit_pkg.sv ----
package map_unit_pkg;

  // ****************************************
  // Command encoding
  // ****************************************
  localparam logic [2:0] op_no_io           = 3'h0;
  localparam logic [2:0] op_data_in_first   = 3'h1;
  localparam logic [2:0] op_data_out_first  = 3'h2;
  localparam logic [2:0] op_data_out_second = 3'h4;
  localparam logic [2:0] op_data_in_third   = 3'h5;
  localparam logic [2:0] op_data_out_third  = 3'h6;
  localparam logic [1:0] flag_clear         = 2'h2;
  localparam logic [1:0] flag_pulse         = 2'h3;
  localparam logic [5:0] map_main_code      = 6'h02;
  localparam logic [5:0] map_aux_code       = 6'h03;

  // ****************************************
  // Status word fields (bit 0 of the word is the msb)
  // ****************************************
  localparam int st_prog_on    = 15;
  localparam int st_chan_on    = 14;
  localparam int st_inhibit    = 13;
  localparam int st_utility_on = 9;
  localparam int st_target_hi  = 8;
  localparam int st_target_lo  = 7;
  localparam int st_sc_bank    = 5;
  localparam int st_prog_bank  = 0;
  localparam logic [15:0] status_reset = 16'h0000;

  // ****************************************
  // Page lookup request and result fields
  // ****************************************
  localparam int rq_sel     = 15;
  localparam int rq_page_hi = 14;
  localparam int rq_page_lo = 10;
  localparam int rq_bank    = 9;
  localparam int rq_keep_lo = 7;
  localparam int res_phys_hi = 6;

  // ****************************************
  // Table entry fields and block transfer
  // ****************************************
  localparam int ent_page_hi = 15;
  localparam int ent_page_lo = 10;
  localparam int ent_phys_hi = 7;
  localparam logic [6:0]  block_words = 7'h40;
  localparam logic [15:0] end_marker  = 16'hffff;

  // ****************************************
  // Map numbers
  // ****************************************
  localparam logic [1:0] map_bank_a  = 2'h0;
  localparam logic [1:0] map_bank_b  = 2'h1;
  localparam logic [1:0] map_channel = 2'h2;
  localparam logic [1:0] map_utility = 2'h3;

  typedef enum logic [2:0] {
    xfer_idle  = 3'b001,
    xfer_fetch = 3'b010,
    xfer_store = 3'b100
  } xfer_state_type;

  // Channel select or program bank to map number
  function automatic logic [1:0] map_pick(input logic chan, input logic bank);
    map_pick = chan ? map_channel : (bank ? map_bank_b : map_bank_a);
  endfunction

endpackage

// ---- map_table_store.sv ----
`timescale 1ns/1ns
module map_table_store
  import map_unit_pkg::*;
#(
  parameter int maps  = 4,
  parameter int pages = 64,
  parameter int width = 8
)
(
  input  wire logic             clk,
  input  wire logic             wr_en,
  input  wire logic [1:0]       wr_map,
  input  wire logic [5:0]       wr_page,
  input  wire logic [width-1:0] wr_data,
  input  wire logic [1:0]       rd_a_map,
  input  wire logic [5:0]       rd_a_page,
  output logic      [width-1:0] rd_a_data,
  input  wire logic [1:0]       rd_b_map,
  input  wire logic [5:0]       rd_b_page,
  output logic      [width-1:0] rd_b_data
);

  logic [width-1:0] table_mem [maps*pages];

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      table_mem[{wr_map, wr_page}] <= wr_data;
    end
  end

  assign rd_a_data = table_mem[{rd_a_map, rd_a_page}];
  assign rd_b_data = table_mem[{rd_b_map, rd_b_page}];

endmodule

// ---- single_cycle_tracker.sv ----
`timescale 1ns/1ns
module single_cycle_tracker
  import map_unit_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic clear,
  input  wire logic start,
  input  wire logic cpu_ref,
  output logic      hit
);

  // Counts program references still to come, up to and including the mapped one
  logic [1:0] waiting;

  assign hit = (waiting == 2'h1) && cpu_ref;

  always_ff @(posedge clk)
  begin
    if (!resetn || clear)
    begin
      waiting <= 2'h0;
    end
    else if (start)
    begin
      waiting <= 2'h2;
    end
    else if (cpu_ref && waiting != 2'h0)
    begin
      waiting <= waiting - 2'h1;
    end
  end

endmodule

// ---- map_unit_properties.sv ----
`timescale 1ns/1ns
module map_unit_checker
  import map_unit_pkg::*;
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        io_strobe,
  input wire logic [2:0]  io_op,
  input wire logic [1:0]  io_flag,
  input wire logic [5:0]  io_code,
  input wire logic [15:0] io_wdata,
  input wire logic [15:0] io_rdata,
  input wire logic        io_done,
  input wire logic        busy,
  input wire logic        int_request,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic        mem_ack,
  input wire logic        ref_valid,
  input wire logic        ref_channel,
  input wire logic [5:0]  ref_page,
  input wire logic [7:0]  mapped_page,
  input wire logic        mapped_valid,
  input wire logic        mapped_translated,
  input wire logic [15:0] translation_status_word
);
  logic [6:0] beats;
  logic       clr;
  logic       go;
  assign clr = io_strobe && io_code == map_aux_code && io_flag == flag_clear;
  assign go = io_strobe && !busy && io_code == map_main_code;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ****************************************
  // Memory beats of the running transfer
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!busy)
      beats <= 7'h0;
    else if (mem_req && mem_ack)
      beats <= beats + 7'h1;
  end
  sequence s_beat;
    mem_req && mem_ack && !clr;
  endsequence
  sequence s_gap;
    !mem_req ##1 (mem_req || !busy);
  endsequence
  a_status_write: assert property (
    go && io_op == op_data_out_first && !int_request
    |=> io_done && translation_status_word == ($past(io_wdata) & 16'hdfff))
    else $error("status write wrong");
  a_status_read: assert property (
    go && io_op == op_data_in_first |=> io_done && io_rdata == $past(translation_status_word))
    else $error("status read wrong");
  a_int_inhibit: assert property (
    int_request && !clr |=> translation_status_word[st_inhibit])
    else $error("inhibit not set");
  a_clear_map: assert property (
    clr && !int_request |=> io_done && !busy && !mem_req && translation_status_word == 16'h0)
    else $error("clear incomplete");
  a_chan_off: assert property (
    ref_valid && ref_channel && !translation_status_word[st_chan_on]
    |=> mapped_valid && !mapped_translated && mapped_page == {2'h0, $past(ref_page)})
    else $error("channel ref translated");
  a_req_hold: assert property (
    mem_req && !mem_ack && !clr |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request dropped");
  a_addr_step: assert property (
    s_beat |=> (!busy || mem_addr == $past(mem_addr) + 16'h1) ##0 s_gap)
    else $error("address step wrong");
  a_block_bound: assert property (
    busy |-> beats <= block_words)
    else $error("too many words");
  a_block_done: assert property (
    $fell(busy) && $past(resetn) |-> io_done)
    else $error("no done after transfer");
  a_other_code: assert property (
    io_strobe && !busy && io_code != map_main_code && io_code != map_aux_code |=> !io_done)
    else $error("foreign code answered");
endmodule
bind memory_map_unit_control map_unit_checker u_chk (.*);

// ---- main_memory_model.sv ----
`timescale 1ns/1ns
module main_memory_model
(
  input  wire logic        clk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  input  wire logic [1:0]  mem_delay,
  output logic      [15:0] mem_rdata,
  output logic             mem_ack
);
  logic [15:0] store [0:511];
  logic [1:0]  wait_left;
  initial
  begin
    mem_ack = 1'b0;
    mem_rdata = 16'h0;
    wait_left = 2'h0;
  end
  // Variable wait; data inverts while not acked
  always @(posedge clk)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack)
    begin
      if (wait_left != 2'h0)
        wait_left <= wait_left - 2'h1;
      else
      begin
        mem_ack <= 1'b1;
        wait_left <= mem_delay;
        mem_rdata <= store[mem_addr[8:0]];
        if (mem_we)
          store[mem_addr[8:0]] <= mem_wdata;
      end
    end
  end
endmodule

// ---- tb.sv ----
`timescale 1ns/1ns
module tb;
  import map_unit_pkg::*;
  logic        clk, resetn, io_strobe, io_done, busy, int_request, mem_req, mem_we, mem_ack;
  logic        ref_valid, ref_channel, ref_indirect, mapped_valid, mapped_translated;
  logic [2:0]  io_op;
  logic [1:0]  io_flag, mem_delay;
  logic [5:0]  io_code, ref_page;
  logic [7:0]  mapped_page;
  logic [15:0] io_wdata, io_rdata, mem_addr, mem_wdata, mem_rdata, translation_status_word, w;
  logic [16:0] q_io[$];
  logic [9:0]  q_map[$];
  logic [16:0] n;
  logic [9:0]  m;
  int          fails, compares, seed, i;
  memory_map_unit_control DUT (.*);
  main_memory_model mem (.*);
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
    mem_delay <= 2'($random(seed));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    check(16'(q_io.size() + q_map.size()), 16'h0);
    if (fails == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ****************************************
  // Drivers
  // ****************************************
  task automatic cmd(input logic [2:0] op, input logic [1:0] fl, input logic [5:0] code,
                     input logic [15:0] d, input logic [17:0] note);
    @(posedge clk);
    if (note[17])
      q_io.push_back(note[16:0]);
    io_strobe <= 1'b1;
    io_op <= op;
    io_flag <= fl;
    io_code <= code;
    io_wdata <= d;
    @(posedge clk);
    io_strobe <= 1'b0;
  endtask
  task automatic mref(input logic ch, input logic ind, input logic [5:0] pg,
                      input logic [9:0] e);
    @(posedge clk);
    q_map.push_back(e);
    ref_valid <= 1'b1;
    ref_channel <= ch;
    ref_indirect <= ind;
    ref_page <= pg;
    @(posedge clk);
    ref_valid <= 1'b0;
  endtask
  task automatic pulse_int;
    @(posedge clk);
    int_request <= 1'b1;
    @(posedge clk);
    int_request <= 1'b0;
  endtask
  task automatic wait_idle;
    @(negedge clk);
    for (i = 0; i < 3000 && busy !== 1'b0; i++)
      @(negedge clk);
    if (busy !== 1'b0)
    begin
      fails++;
      tally_and_finish;
    end
  endtask
  // ****************************************
  // Result watcher
  // ****************************************
  always @(negedge clk)
  begin
    if (resetn === 1'b1 && io_done !== 1'b0)
    begin
      if (q_io.size() == 0)
        check(16'h0, 16'h1);
      else
      begin
        n = q_io.pop_front();
        if (n[16])
          check(io_rdata, n[15:0]);
      end
    end
    if (resetn === 1'b1 && mapped_valid !== 1'b0)
    begin
      m = (q_map.size() != 0) ? q_map.pop_front() : 10'h3ff;
      if (m[9])
        check({7'h0, mapped_translated, mapped_page}, {7'h0, m[8:0]});
    end
  end
  initial
  begin
    seed = 25193;
    resetn = 1'b0;
    io_strobe = 1'b0;
    io_op = 3'h0;
    io_flag = 2'h0;
    io_code = 6'h0;
    io_wdata = 16'h0;
    int_request = 1'b0;
    ref_valid = 1'b0;
    ref_channel = 1'b0;
    ref_indirect = 1'b0;
    ref_page = 6'h0;
    for (int k = 0; k < 64; k++)
      mem.store[9'h100 + k] = {6'(k), 2'h0, 8'(k) ^ 8'ha5};
    mem.store[9'h140] = 16'h0011;
    mem.store[9'h1c0] = 16'hbeef;
    mem.store[9'h030] = 16'h1477;
    mem.store[9'h031] = 16'hffff;
    mem.store[9'h040] = 16'h0cc3;
    mem.store[9'h041] = 16'hffff;
    mem.store[9'h042] = 16'h14c5;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    cmd(op_data_in_first, 2'h0, map_main_code, 16'h0, {2'b11, 16'h0});
    for (int k = 0; k < 4; k++)
    begin
      w = 16'($random(seed)) & 16'he3a1;
      cmd(op_data_out_first, 2'h0, map_main_code, w, 18'h20000);
      cmd(op_data_in_first, 2'h0, map_main_code, 16'h0, {2'b11, w & 16'hdfff});
    end
    pulse_int;
    cmd(op_data_in_first, 2'h0, map_main_code, 16'h0, {2'b11, w | 16'h2000});
    cmd(op_data_in_first, 2'h0, 6'h04, 16'h0, 18'h0);
    for (int k = 0; k < 3; k++)
    begin
      w = {k == 2, 5'(k + 5), k == 1, 2'h0, 7'(k + 97)};
      cmd(op_data_out_second, 2'h0, map_main_code, w, 18'h20000);
      cmd(op_data_out_first, 2'h0, map_aux_code, w & 16'hfe00, 18'h20000);
      cmd(op_data_in_first, 2'h0, map_aux_code, 16'h0, {2'b11, w});
    end
    cmd(op_data_out_first, 2'h0, map_main_code, 16'h0, 18'h20000);
    cmd(op_data_out_third, 2'h0, map_main_code, 16'h0100, 18'h20000);
    wait_idle;
    cmd(op_data_in_third, 2'h0, map_main_code, 16'h8180, 18'h20000);
    wait_idle;
    for (int k = 0; k < 64; k++)
      check(mem.store[9'h180 + k], {6'(k), 2'h0, 8'(k) ^ 8'ha5});
    check(mem.store[9'h1c0], 16'hbeef);
    cmd(op_data_out_first, 2'h0, map_main_code, 16'h0380, 18'h20000);
    cmd(op_data_out_third, 2'h0, map_main_code, 16'h0030, 18'h20000);
    wait_idle;
    cmd(op_data_out_third, 2'h0, map_main_code, 16'h0040, 18'h20000);
    wait_idle;
    mref(1'b0, 1'b0, 6'h5, {2'b11, 8'h77});
    mref(1'b0, 1'b0, 6'h3, {2'b11, 8'hc3});
    mref(1'b1, 1'b0, 6'h3, {2'b10, 8'h03});
    cmd(op_data_out_first, 2'h0, map_main_code, 16'h8000, 18'h20000);
    mref(1'b0, 1'b0, 6'h0, {2'b10, 8'h00});
    mref(1'b0, 1'b1, 6'h0, 10'h0);
    mref(1'b0, 1'b0, 6'h0, {2'b11, 8'ha5});
    cmd(op_data_out_first, 2'h0, map_main_code, 16'h8001, 18'h20000);
    mref(1'b0, 1'b1, 6'h6, 10'h0);
    mref(1'b0, 1'b0, 6'h6, {2'b11, 8'h62});
    pulse_int;
    mref(1'b0, 1'b0, 6'h6, {2'b10, 8'h06});
    cmd(op_data_out_first, 2'h0, map_main_code, 16'h4000, 18'h20000);
    mref(1'b1, 1'b0, 6'h7, {2'b11, 8'h63});
    cmd(op_data_out_first, 2'h0, map_main_code, 16'h0020, 18'h20000);
    cmd(op_no_io, flag_pulse, map_main_code, 16'h0, 18'h20000);
    mref(1'b0, 1'b0, 6'h6, {2'b10, 8'h06});
    mref(1'b1, 1'b0, 6'h6, {2'b10, 8'h06});
    mref(1'b0, 1'b0, 6'h6, {2'b11, 8'h62});
    mref(1'b0, 1'b0, 6'h6, {2'b10, 8'h06});
    cmd(op_data_out_first, 2'h0, map_main_code, 16'h4000, 18'h20000);
    cmd(op_data_out_third, 2'h0, map_main_code, 16'h0100, 18'h0);
    cmd(op_data_in_first, 2'h0, map_main_code, 16'h0, 18'h0);
    cmd(op_no_io, flag_clear, map_aux_code, 16'h0, 18'h20000);
    wait_idle;
    cmd(op_data_in_first, 2'h0, map_main_code, 16'h0, {2'b11, 16'h0});
    mref(1'b1, 1'b0, 6'h7, {2'b10, 8'h07});
    repeat (4) @(posedge clk);
    tally_and_finish;
  end
endmodule
